// ---- core/scw_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// Write-only link master: one request writes START, address, register, N bytes, STOP
module scw_master (
    input wire logic CORE_CLK,              // System clock
    input wire logic RST,                   // Async reset, high
    scw_link_if.master LINK,                // Two-wire link
    input wire logic [6:0] DEV_ADDR,        // Target address
    input wire logic [7:0] REG_ADDR,        // First register
    input wire logic START_REQ,             // Begin a frame (pulse)
    input wire logic [7:0] WR_DATA,         // Next data byte
    input wire logic WR_VALID,              // Data byte offered
    output logic WR_TAKEN,                  // Byte consumed (pulse)
    output logic BUSY,                      // Frame in progress
    output logic NACK                       // Last frame saw no acknowledge
);
    import scw_pkg::*;

    typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} scw_mst_t;
    scw_mst_t st_r;
    logic [8:0] qcnt_r;
    logic [1:0] ph_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic [1:0] byte_r;
    logic scl_r, sda_r, sda_s1_r, sda_s2_r;
    wire q_tick = (qcnt_r == QTR_LAST);

    // ------------------------------------------------------------
    // Quarter-period timebase; SCL is made here, so it is not a second domain
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            qcnt_r <= 9'h000;
        end else begin
            qcnt_r <= q_tick ? 9'h000 : qcnt_r + 9'h001;
        end
    end

    // Acknowledge sampled through two flops
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
        end else begin
            sda_s1_r <= LINK.sda;
            sda_s2_r <= sda_s1_r;
        end
    end

    // Frame sequencer; bit and ack slots move SDA only at phase 0 (SCL low), ph 2..3 SCL high
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st_r <= M_IDLE;
            ph_r <= 2'h0;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            byte_r <= 2'h0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            WR_TAKEN <= 1'b0;
            BUSY <= 1'b0;
            NACK <= 1'b0;
        end else begin
            WR_TAKEN <= 1'b0;
            case (st_r)
                M_IDLE: begin
                    scl_r <= 1'b1;
                    sda_r <= 1'b1;
                    if (START_REQ) begin
                        st_r <= M_START;
                        ph_r <= 2'h0;
                        BUSY <= 1'b1;
                        NACK <= 1'b0;
                        byte_r <= 2'h0;
                        sh_r <= {DEV_ADDR, RW_WRITE};
                    end
                end
                M_START: if (q_tick) begin
                    ph_r <= ph_r + 2'h1;
                    if (ph_r == 2'h1) sda_r <= 1'b0;      // SDA falls, SCL high
                    if (ph_r == 2'h3) begin
                        scl_r <= 1'b0;
                        st_r <= M_BIT;
                        bit_r <= 3'h7;
                    end
                end
                M_BIT, M_ACK: if (q_tick) begin
                    ph_r <= ph_r + 2'h1;
                    case (ph_r)
                        2'h0: sda_r <= (st_r == M_ACK) ? 1'b1 : sh_r[7];
                        2'h1: scl_r <= 1'b1;
                        2'h2: if (st_r == M_ACK && sda_s2_r) NACK <= 1'b1;
                        default: begin
                            scl_r <= 1'b0;
                            if (st_r == M_BIT) begin
                                sh_r <= {sh_r[6:0], 1'b0};
                                bit_r <= bit_r - 3'h1;
                                if (bit_r == 3'h0) st_r <= M_ACK;
                            end else if (NACK || !WR_VALID) begin
                                st_r <= M_STOP;
                            end else begin
                                // Byte 2 is the register, then data
                                sh_r <= (byte_r == 2'h0) ? REG_ADDR : WR_DATA;
                                WR_TAKEN <= (byte_r != 2'h0);
                                if (byte_r != 2'h2) byte_r <= byte_r + 2'h1;
                                bit_r <= 3'h7;
                                st_r <= M_BIT;
                            end
                        end
                    endcase
                end
                default: if (q_tick) begin              // M_STOP
                    ph_r <= ph_r + 2'h1;
                    if (ph_r == 2'h0) sda_r <= 1'b0;
                    if (ph_r == 2'h1) scl_r <= 1'b1;
                    if (ph_r == 2'h3) begin
                        sda_r <= 1'b1;                    // SDA rises, SCL high
                        st_r <= M_IDLE;
                        BUSY <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Open-drain drive: enable low pulls the line low
    assign LINK.scl_o = 1'b0;
    assign LINK.scl_oe_n = scl_r;
    assign LINK.sda_m_o = 1'b0;
    assign LINK.sda_m_oe_n = sda_r;
endmodule : scw_master
`default_nettype wire

// ---- core/scw_pkg.sv ----
package scw_pkg;
    // ------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h72;      // Fixed device address 1110010
    localparam logic RW_WRITE = 1'b0;               // Direction bit value for write
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ACK_SLOT = 4'h8;         // Bit index of the acknowledge clock
    // ------------------------------------------------------------
    // Setting registers
    // ------------------------------------------------------------
    localparam int NUM_REGS = 4;
    localparam logic [7:0] REG_LAST = 8'h03;        // Auto-increment wraps after this
    localparam logic [7:0] REG_FIRST = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ------------------------------------------------------------
    // Master timing
    // ------------------------------------------------------------
    localparam int CORE_MHZ = 50;
    localparam int SCL_KHZ = 100;
    localparam int QTR_CYC = (CORE_MHZ * 1000) / (SCL_KHZ * 4); // Quarter SCL period
    localparam logic [8:0] QTR_LAST = 9'(QTR_CYC - 1);
endpackage : scw_pkg

// ---- core/scw_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Open-drain two-wire link; enables are active low (drive low when enable low)
interface scw_link_if;
    logic scl_o;     // Master clock level request
    logic scl_oe_n;  // Master pulls SCL low when 0
    logic sda_m_o;   // Master SDA level
    logic sda_m_oe_n; // Master pulls SDA low when 0
    logic sda_s_o;   // Device SDA level
    logic sda_s_oe_n; // Device pulls SDA low when 0
    logic scl;       // Resolved SCL
    logic sda;       // Resolved SDA
    // Wired-AND resolution of the pulled-up lines
    assign scl = scl_oe_n;
    assign sda = sda_m_oe_n & sda_s_oe_n;
    modport master (output scl_o, scl_oe_n, sda_m_o, sda_m_oe_n, input scl, sda);
    modport device (output sda_s_o, sda_s_oe_n, input scl, sda);
endinterface : scw_link_if
`default_nettype wire

// ---- core/scw_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - SDA stable while SCL high
// - Idle bus released, both lines high
// - START begins access, device starts receiving
// - STOP ends the current access
// - Whole bytes, any number per frame
// - After eighth fall, receiver pulls acknowledge
// - Release SDA at ninth falling edge
// - First byte: 7-bit address plus direction
// - Write only, never drive register data
// - Address MSB first, eighth bit low
// - Bytes after address are write data
// - Respond only to address 1110010
// - Second byte selects register address
// - Data stored, register address auto-increments
// - Increment from 00000011 wraps to 00000000
// - Byte lands at its bit-0 SCL rise; here the registers take it 2-3 core clocks after that rise
module scw_device (
    input wire logic CORE_CLK,              // System clock
    input wire logic RST,                   // Async reset, high
    scw_link_if.device LINK,                // Two-wire link; SCL clocks link logic
    output logic [7:0] REG0,                // Setting register 0
    output logic [7:0] REG1,                // Setting register 1
    output logic [7:0] REG2,                // Setting register 2
    output logic [7:0] REG3,                // Setting register 3
    output logic UPDATED                    // A register changed (pulse)
);
    import scw_pkg::*;

    typedef enum {D_IDLE, D_ADDR, D_REG, D_DATA, D_IGNORE} scw_dev_t;
    scw_dev_t st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] ptr_r;
    logic ack_r;
    logic start_t_r, stop_t_r;
    logic [7:0] regs_r [NUM_REGS];
    logic wr_tog_r;
    logic [7:0] wr_val_r;
    logic [1:0] wr_idx_r;
    logic [2:0] tog_sync_r;
    logic stop_seen_r;

    function automatic logic [7:0] next_reg(input logic [7:0] a);
        next_reg = (a == REG_LAST) ? REG_FIRST : a + 8'h01;
    endfunction : next_reg

    // ------------------------------------------------------------
    // Frame conditions: SDA edges while SCL high, as toggles clocked by SDA
    // ------------------------------------------------------------
    // SDA is sampled as a clock here; these see START/STOP directly
    always_ff @(negedge LINK.sda or posedge RST) begin
        if (RST) start_t_r <= 1'b0;
        else if (LINK.scl) start_t_r <= ~start_t_r;
    end

    always_ff @(posedge LINK.sda or posedge RST) begin
        if (RST) stop_t_r <= 1'b0;
        else if (LINK.scl) stop_t_r <= ~stop_t_r;
    end

    // Last toggles seen at an SCL rise; a START since then restarts the frame
    logic start_seen_r;
    wire new_frame = (start_t_r != start_seen_r);
    wire stopped = (stop_t_r != stop_seen_r);

    // ------------------------------------------------------------
    // Receiver on SCL; byte is 8 data rises then an ack rise
    // ------------------------------------------------------------
    always_ff @(posedge LINK.scl or posedge RST) begin
        if (RST) begin
            st_r <= D_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= REG_FIRST;
            start_seen_r <= 1'b0;
            stop_seen_r <= 1'b0;
            wr_tog_r <= 1'b0;
            wr_val_r <= 8'h00;
            wr_idx_r <= 2'h0;
        end else begin
            start_seen_r <= start_t_r;
            stop_seen_r <= stop_t_r;
            if (new_frame) begin
                st_r <= D_ADDR;
                sh_r <= {7'h00, LINK.sda};
                bit_r <= 4'h1;
            end else if (stopped || st_r == D_IDLE || st_r == D_IGNORE) begin
                if (stopped) st_r <= D_IDLE;
            end else if (bit_r == ACK_SLOT) begin
                bit_r <= 4'h0;                                   // Ack clock rise
            end else begin
                sh_r <= {sh_r[6:0], LINK.sda};                   // MSB first
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h7) begin
                    case (st_r)
                        D_ADDR: st_r <= ({sh_r[6:0], LINK.sda} == {SLAVE_ADDR[6:0], RW_WRITE})
                                        ? D_REG : D_IGNORE;
                        D_REG: begin
                            ptr_r <= {sh_r[6:0], LINK.sda};
                            st_r <= D_DATA;
                        end
                        default: begin
                            wr_val_r <= {sh_r[6:0], LINK.sda};   // At bit-0 rise
                            wr_idx_r <= ptr_r[1:0];
                            wr_tog_r <= ~wr_tog_r;
                            ptr_r <= next_reg(ptr_r);
                        end
                    endcase
                end
            end
        end
    end

    // Ack driven from eighth fall to ninth fall; data never driven
    always_ff @(negedge LINK.scl or posedge RST) begin
        if (RST) ack_r <= 1'b0;
        else ack_r <= (bit_r == ACK_SLOT) && (st_r == D_REG || st_r == D_DATA) && !stopped;
    end

    assign LINK.sda_s_o = 1'b0;
    assign LINK.sda_s_oe_n = ~ack_r;                              // Released when idle

    // ------------------------------------------------------------
    // Core side: toggle crossing; value/index set at the same SCL rise as the toggle, stable before the core sees it
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) tog_sync_r <= 3'h0;
        else tog_sync_r <= {tog_sync_r[1:0], wr_tog_r};
    end

    // Register file and change pulse; latency 2-3 core clocks after the rise
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < NUM_REGS; i++) regs_r[i] <= REG_RESET;
            UPDATED <= 1'b0;
        end else begin
            UPDATED <= tog_sync_r[2] ^ tog_sync_r[1];
            if (tog_sync_r[2] ^ tog_sync_r[1]) regs_r[wr_idx_r] <= wr_val_r;
        end
    end

    assign REG0 = regs_r[0];
    assign REG1 = regs_r[1];
    assign REG2 = regs_r[2];
    assign REG3 = regs_r[3];
endmodule : scw_device
`default_nettype wire

// ---- tb/scw_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// Link watcher
// --------------------------------------------
module scw_properties (
    input wire logic CORE_CLK, // System clock
    input wire logic RST, // Async reset, high
    input wire logic scl, // Resolved clock line
    input wire logic sda, // Resolved data line
    input wire logic sda_m_oe_n, // Master data pull
    input wire logic sda_s_oe_n // Device ack pull
);
    import scw_pkg::*;
    logic scl_q_r, sda_q_r, frm_r, sel_r;
    logic [3:0] bit_r;
    logic [2:0] byt_r;
    logic [7:0] sh_r;
    wire logic rise = scl & ~scl_q_r;
    wire logic fall = ~scl & scl_q_r;
    wire logic strt = scl & scl_q_r & sda_q_r & ~sda;
    wire logic stp = scl & scl_q_r & ~sda_q_r & sda;
    wire logic ours = sh_r == {SLAVE_ADDR, RW_WRITE};
    // Oversample the lines; SCL is far slower than CORE_CLK
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl;
            sda_q_r <= sda;
        end
    end
    // Frame spans START to STOP
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            frm_r <= 1'b0;
        end else if (strt | stp) begin
            frm_r <= strt;
        end
    end
    // SCL rises within a byte, 9 on the ack clock
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            bit_r <= 4'h0;
        end else if (strt || (fall && bit_r == 4'h9)) begin
            bit_r <= 4'h0;
        end else if (rise) begin
            bit_r <= bit_r + 4'h1;
        end
    end
    // First byte decides whether the device is addressed
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            byt_r <= 3'h0;
            sel_r <= 1'b0;
            sh_r <= 8'h00;
        end else if (strt) begin
            byt_r <= 3'h0;
            sel_r <= 1'b0;
        end else begin
            if (rise && bit_r < 4'h8) begin
                sh_r <= {sh_r[6:0], sda};
            end
            if (fall && bit_r == 4'h8 && byt_r == 3'h0) begin
                sel_r <= ours;
            end
            if (fall && bit_r == 4'h9 && byt_r != 3'h7) begin
                byt_r <= byt_r + 3'h1;
            end
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence s_ack_in; fall && bit_r == 4'h8; endsequence
    sequence s_ack_out; fall && bit_r == 4'h9; endsequence
    chk_idle_released: assert property (!frm_r && !strt |-> scl && sda)
        else $error("idle bus not released");
    chk_mst_data_steady: assert property (frm_r && scl && scl_q_r && $changed(sda_m_oe_n) |-> sda_m_oe_n)
        else $error("master data moved with clock high");
    chk_dev_data_steady: assert property ($changed(sda_s_oe_n) |-> !scl)
        else $error("device data moved with clock high");
    chk_ack_window: assert property (!sda_s_oe_n |-> (bit_r == 4'h8 && (!scl || !scl_q_r)) || bit_r == 4'h9)
        else $error("device pulled outside ack slot");
    chk_addr_acked: assert property (s_ack_in ##0 (byt_r == 3'h0 && ours) |-> ##[0:2] !sda_s_oe_n)
        else $error("own address not acknowledged");
    chk_data_acked: assert property (s_ack_in ##0 (byt_r != 3'h0 && sel_r) |-> ##[0:2] !sda_s_oe_n)
        else $error("data byte not acknowledged");
    chk_ack_release: assert property (s_ack_out |-> ##[0:1] sda_s_oe_n)
        else $error("ack not released at ninth fall");
    chk_foreign_silent: assert property (frm_r && !sel_r && (byt_r != 3'h0 || (bit_r >= 4'h8 && !ours)) |-> sda_s_oe_n)
        else $error("device answered a foreign frame");
endmodule : scw_properties
`default_nettype wire

// ---- tb/tb_i2c_write_only_config_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------
// Master writes settings into the device
// --------------------------------------------
module tb_i2c_write_only_config_slave;
    import scw_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic start_req = 1'b0;
    logic wr_valid = 1'b0;
    logic [6:0] dev_addr = 7'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_taken, busy, nack, updated;
    logic [7:0] regs [4];
    logic [7:0] exp_regs [4] = '{default: 8'h00};
    int miscompares = 0;
    int comparisons = 0;
    int upd_cnt = 0;
    scw_link_if u_scw_link_if ();
    scw_master u_scw_master (.CORE_CLK(core_clk), .RST(rst), .LINK(u_scw_link_if),
        .DEV_ADDR(dev_addr), .REG_ADDR(reg_addr), .START_REQ(start_req), .WR_DATA(wr_data),
        .WR_VALID(wr_valid), .WR_TAKEN(wr_taken), .BUSY(busy), .NACK(nack));
    scw_device u_scw_device (.CORE_CLK(core_clk), .RST(rst), .LINK(u_scw_link_if),
        .REG0(regs[0]), .REG1(regs[1]), .REG2(regs[2]), .REG3(regs[3]), .UPDATED(updated));
    scw_properties u_scw_properties (.CORE_CLK(core_clk), .RST(rst), .scl(u_scw_link_if.scl),
        .sda(u_scw_link_if.sda), .sda_m_oe_n(u_scw_link_if.sda_m_oe_n),
        .sda_s_oe_n(u_scw_link_if.sda_s_oe_n));
    // Clock and update pulse tally
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) if (updated === 1'b1) upd_cnt++;
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic results();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // One frame; the next byte is offered until the master takes it
    task automatic write_frame(input logic [6:0] dev, input logic [7:0] ra, input int n,
        input logic [7:0] d [4], input logic exp_nack);
        int i;
        int w;
        int base;
        i = 0;
        w = 0;
        base = upd_cnt;
        @(posedge core_clk);
        dev_addr <= dev;
        reg_addr <= ra;
        wr_data <= d[0];
        wr_valid <= (n > 0);
        start_req <= 1'b1;
        @(posedge core_clk);
        start_req <= 1'b0;
        do begin
            @(posedge core_clk);
            w++;
            if (wr_taken === 1'b1) begin
                i++;
                wr_data <= d[i % 4];
                wr_valid <= (i < n);
            end
        end while (busy !== 1'b0 && w < 60000);
        cmp8(8'(w >= 60000), 8'h00);
        repeat (8) @(posedge core_clk);
        if (!exp_nack) begin
            for (int k = 0; k < n; k++) begin
                exp_regs[2'(ra + 8'(k))] = d[k];
            end
        end
        cmp8({7'h00, nack}, {7'h00, exp_nack});
        cmp8(8'(upd_cnt - base), exp_nack ? 8'h00 : 8'(n));
        for (int k = 0; k < 4; k++) begin
            cmp8(regs[k], exp_regs[k]);
        end
    endtask : write_frame
    // Main sequence; foreign frames must leave the settings alone
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        cmp8({6'h00, u_scw_link_if.scl, u_scw_link_if.sda}, 8'h03);
        for (int k = 0; k < 4; k++) begin
            cmp8(regs[k], REG_RESET);
        end
        write_frame(SLAVE_ADDR, 8'h03, 3, '{8'hA5, 8'h5A, 8'hC3, 8'h00}, 1'b0);
        write_frame(7'h73, 8'h00, 1, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
        write_frame(7'h32, 8'h01, 1, '{8'h55, 8'h66, 8'h77, 8'h88}, 1'b1);
        write_frame(SLAVE_ADDR, 8'h01, 1, '{8'h3C, 8'h00, 8'h00, 8'h00}, 1'b0);
        write_frame(SLAVE_ADDR, 8'h02, 4, '{8'h81, 8'h42, 8'h24, 8'h18}, 1'b0);
        results();
    end
    // Watchdog some 360 us beyond the roughly 1540 us of the five frames
    initial begin
        #1900000;
        miscompares++;
        $display("Error %0t: watchdog expired", $time);
        results();
    end
endmodule : tb_i2c_write_only_config_slave
`default_nettype wire
